// ===== verilog/icc_capture.sv
// Input capture channel with APB register access
`timescale 1ns/1ps
module icc_capture (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic capture_pin_i,
   input wire icc_pkg::icc_timers_type timers_i,
   input wire logic cpu_idle_i,
   input wire logic cpu_sleep_i,
   output logic irq_o,
   output logic wake_o
);
   import icc_pkg::*;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   icc_ctrl_type ctrl_r;
   logic mod_disable_r;
   logic disabled_r;
   logic irq_flag_r;
   logic irq_en_r;
   logic overflow_r;
   logic [ICC_TW-1:0] fifo_mem [ICC_DEPTH];
   logic [1:0] wr_ptr_r;
   logic [1:0] rd_ptr_r;
   logic [2:0] count_r;
   logic [3:0] presc_r;
   logic [1:0] cpi_cnt_r;
   icc_mode_type last_mode_r;
   logic [31:0] prdata_r;
   logic rise;
   logic fall;
   logic run;
   logic edge_hit;
   logic capture;
   logic irq_evt;
   logic wr_acc;
   logic rd_acc;
   logic buf_pop;
   logic mode_changed;
   logic [ICC_TW-1:0] sel_time;

   icc_edge_detect u_edge (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .pin_i(capture_pin_i),
      .rise_o(rise),
      .fall_o(fall)
   );

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
      is_addr = (a == ofs);
   endfunction : is_addr

   // ------------------------------------------------------------
   // APB access, zero wait states
   // ------------------------------------------------------------
   assign pready_o = 1'b1;
   assign wr_acc = psel_i & penable_i & pwrite_i;
   assign rd_acc = psel_i & penable_i & ~pwrite_i;
   assign pslverr_o = psel_i & penable_i & ~(is_addr(paddr_i, ICC_CTRL_OFS) |
      is_addr(paddr_i, ICC_BUF_OFS) | is_addr(paddr_i, ICC_IRQ_OFS) |
      is_addr(paddr_i, ICC_PMD_OFS));
   assign buf_pop = rd_acc & is_addr(paddr_i, ICC_BUF_OFS) & ~disabled_r &
      (count_r != 3'd0);

   // Disable bit itself stays reachable so software can undo it
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         mod_disable_r <= 1'b0;
      end else if (wr_acc && is_addr(paddr_i, ICC_PMD_OFS)) begin
         mod_disable_r <= pwdata_i[0];
      end
   end

   // One cycle delay on the disable going into force
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         disabled_r <= 1'b0;
      end else begin
         disabled_r <= mod_disable_r;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         ctrl_r <= icc_ctrl_type'({ICC_CTRL_RST[13], ICC_CTRL_RST[7:5], ICC_CTRL_RST[2:0]});
         irq_en_r <= 1'b0;
      end else if (wr_acc && !disabled_r) begin
         if (is_addr(paddr_i, ICC_CTRL_OFS)) begin
            ctrl_r.stop_in_idle <= pwdata_i[ICC_SIDL_BIT];
            ctrl_r.timer_select <= pwdata_i[ICC_TSEL_BIT];
            ctrl_r.captures_per_interrupt <= pwdata_i[ICC_CPI_LSB +: 2];
            ctrl_r.capture_mode <= icc_mode_type'(pwdata_i[ICC_MODE_LSB +: 3]);
         end
         if (is_addr(paddr_i, ICC_IRQ_OFS)) begin
            irq_en_r <= pwdata_i[ICC_IRQ_EN_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // Capture event selection
   // ------------------------------------------------------------
   // Halt on idle; module-disable freezes all capture state (clock gone), except the pin synchroniser, which keeps sampling
   assign run = ~disabled_r & ~(ctrl_r.stop_in_idle & cpu_idle_i);
   assign mode_changed = (ctrl_r.capture_mode != last_mode_r);

   always_comb begin
      edge_hit = 1'b0;
      case (ctrl_r.capture_mode)
         ICC_OFF: edge_hit = 1'b0;
         ICC_EVERY_EDGE: edge_hit = rise | fall;
         ICC_FALL: edge_hit = fall;
         ICC_RISE: edge_hit = rise;
         ICC_RISE4: edge_hit = rise && (presc_r[1:0] == ICC_PRE4_LAST[1:0]);
         ICC_RISE16: edge_hit = rise && (presc_r == ICC_PRE16_LAST);
         ICC_UNUSED: edge_hit = 1'b0;
         ICC_WAKE: edge_hit = 1'b0;
         default: edge_hit = 1'b0;
      endcase
   end

   assign capture = run & edge_hit & ~mode_changed;

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         presc_r <= 4'h0;
         last_mode_r <= ICC_OFF;
      end else if (!disabled_r) begin
         last_mode_r <= ctrl_r.capture_mode;
         if (mode_changed) begin
            presc_r <= 4'h0;
         end else if (run && rise) begin
            presc_r <= presc_r + 4'h1;
         end
      end
   end

   always_comb begin
      sel_time = ctrl_r.timer_select ? timers_i.second_timer : timers_i.third_timer;
   end

   // ------------------------------------------------------------
   // Capture FIFO
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (capture && count_r != ICC_DEPTH[2:0]) begin
         fifo_mem[wr_ptr_r] <= sel_time;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         wr_ptr_r <= 2'd0;
         rd_ptr_r <= 2'd0;
         count_r <= 3'd0;
      end else begin
         if (capture && count_r != ICC_DEPTH[2:0]) begin
            wr_ptr_r <= wr_ptr_r + 2'd1;
         end
         if (buf_pop) begin
            rd_ptr_r <= rd_ptr_r + 2'd1;
         end
         count_r <= count_r + 3'((capture && count_r != ICC_DEPTH[2:0]) ? 1 : 0)
            - 3'(buf_pop ? 1 : 0);
      end
   end

   // Overflow held until the buffer is drained empty; a new full-capture wins
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         overflow_r <= 1'b0;
      end else if (capture && count_r == ICC_DEPTH[2:0]) begin
         overflow_r <= 1'b1;
      end else if (buf_pop && count_r == 3'd1) begin
         overflow_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Interrupt generation
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         cpi_cnt_r <= 2'd0;
      end else if (!disabled_r && mode_changed) begin
         cpi_cnt_r <= 2'd0;
      end else if (capture) begin
         cpi_cnt_r <= irq_evt ? 2'd0 : cpi_cnt_r + 2'd1;
      end
   end

   always_comb begin
      irq_evt = 1'b0;
      if (capture) begin
         if (ctrl_r.capture_mode == ICC_EVERY_EDGE) begin
            irq_evt = 1'b1;
         end else begin
            irq_evt = (cpi_cnt_r == ctrl_r.captures_per_interrupt);
         end
      end else if (!disabled_r && ctrl_r.capture_mode == ICC_WAKE) begin
         irq_evt = rise & (cpu_sleep_i | cpu_idle_i);
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         irq_flag_r <= 1'b0;
      end else if (irq_evt) begin
         irq_flag_r <= 1'b1;
      end else if (wr_acc && !disabled_r && is_addr(paddr_i, ICC_IRQ_OFS)
            && !pwdata_i[ICC_IRQ_FLAG_BIT]) begin
         irq_flag_r <= 1'b0;
      end
   end

   assign irq_o = irq_flag_r & irq_en_r;
   assign wake_o = irq_flag_r & irq_en_r & (cpu_idle_i | cpu_sleep_i);

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_r <= 32'h0000_0000;
         if (is_addr(paddr_i, ICC_PMD_OFS)) begin
            prdata_r <= {31'h0000_0000, mod_disable_r};
         end else if (disabled_r) begin
            prdata_r <= ICC_INVALID_RD;
         end else if (is_addr(paddr_i, ICC_CTRL_OFS)) begin
            prdata_r[ICC_SIDL_BIT] <= ctrl_r.stop_in_idle;
            prdata_r[ICC_TSEL_BIT] <= ctrl_r.timer_select;
            prdata_r[ICC_CPI_LSB +: 2] <= ctrl_r.captures_per_interrupt;
            prdata_r[ICC_OV_BIT] <= overflow_r;
            prdata_r[ICC_BNE_BIT] <= (count_r != 3'd0);
            prdata_r[ICC_MODE_LSB +: 3] <= ctrl_r.capture_mode;
         end else if (is_addr(paddr_i, ICC_BUF_OFS)) begin
            prdata_r[ICC_TW-1:0] <= fifo_mem[rd_ptr_r];
         end else if (is_addr(paddr_i, ICC_IRQ_OFS)) begin
            prdata_r[ICC_IRQ_FLAG_BIT] <= irq_flag_r;
            prdata_r[ICC_IRQ_EN_BIT] <= irq_en_r;
         end
      end
   end

   assign prdata_o = prdata_r;
endmodule : icc_capture

// ===== common/icc_pkg.sv
// Package for the input capture channel: register map, fields, modes
package icc_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ICC_CTRL_OFS = 8'h00;
   localparam logic [7:0] ICC_BUF_OFS = 8'h04;
   localparam logic [7:0] ICC_IRQ_OFS = 8'h08;
   localparam logic [7:0] ICC_PMD_OFS = 8'h0c;
   // ------------------------------------------------------------
   // Register field positions and constants
   // ------------------------------------------------------------
   localparam int ICC_SIDL_BIT = 13;
   localparam int ICC_TSEL_BIT = 7;
   localparam int ICC_CPI_LSB = 5;
   localparam int ICC_OV_BIT = 4;
   localparam int ICC_BNE_BIT = 3;
   localparam int ICC_MODE_LSB = 0;
   localparam int ICC_IRQ_FLAG_BIT = 1;
   localparam int ICC_IRQ_EN_BIT = 6;
   localparam logic [15:0] ICC_CTRL_WMASK = 16'h20e7;
   localparam logic [15:0] ICC_CTRL_RST = 16'h0000;
   localparam int ICC_DEPTH = 4;
   localparam int ICC_TW = 16;
   localparam logic [3:0] ICC_PRE4_LAST = 4'h3;
   localparam logic [3:0] ICC_PRE16_LAST = 4'hf;
   localparam logic [31:0] ICC_INVALID_RD = 32'hdead_beef;

   typedef enum logic [2:0] {
      ICC_OFF = 3'b000,
      ICC_EVERY_EDGE = 3'b001,
      ICC_FALL = 3'b010,
      ICC_RISE = 3'b011,
      ICC_RISE4 = 3'b100,
      ICC_RISE16 = 3'b101,
      ICC_UNUSED = 3'b110,
      ICC_WAKE = 3'b111
   } icc_mode_type;

   typedef struct packed {
      logic stop_in_idle;
      logic timer_select;
      logic [1:0] captures_per_interrupt;
      icc_mode_type capture_mode;
   } icc_ctrl_type;

   typedef struct packed {
      logic [ICC_TW-1:0] second_timer;
      logic [ICC_TW-1:0] third_timer;
   } icc_timers_type;
endpackage : icc_pkg

// ===== verilog/icc_edge_detect.sv
// Pin synchroniser and edge detector for the capture input
`timescale 1ns/1ps
module icc_edge_detect (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic pin_i,
   output logic rise_o,
   output logic fall_o
);
   logic sync1_r;
   logic sync2_r;
   logic last_r;

   // Second stage alone feeds the edge logic
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         sync1_r <= pin_i;
         sync2_r <= sync1_r;
         last_r <= sync2_r;
      end
   end

   assign rise_o = sync2_r & ~last_r;
   assign fall_o = ~sync2_r & last_r;
endmodule : icc_edge_detect

// ===== verification/icc_capture_chk.sv
// Port-level assertion checker for the input capture channel
`timescale 1ns/1ps
module icc_capture_chk (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic capture_pin_i,
   input wire logic cpu_idle_i,
   input wire logic cpu_sleep_i,
   input wire logic irq_o,
   input wire logic wake_o
);
   import icc_pkg::*;
   logic [7:0] hist;
   wire acc = psel_i && penable_i;
   wire wr = acc && pwrite_i;
   wire mapped = (paddr_i[7:4] == 4'h0) && (paddr_i[1:0] == 2'h0);
   // Pin history spans the sync and edge latency with margin
   wire pin_act = (hist != 8'h00) && (hist != 8'hff);
   wire low_pwr = cpu_idle_i || cpu_sleep_i;
   always_ff @(posedge clk_sys_i) begin
      hist <= {hist[6:0], capture_pin_i};
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   ready_high_a: assert property (pready_o) else $error("pready low");
   err_unmapped_a: assert property (acc && !mapped |-> pslverr_o) else $error("no slverr");
   err_mapped_a: assert property (!(acc && !mapped) |-> !pslverr_o) else $error("bad slverr");
   rdata_hold_a:
   assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
      else $error("prdata moved");
   wake_gate_a: assert property (wake_o |-> irq_o && low_pwr) else $error("stray wake");
   wake_follow_a: assert property (irq_o && low_pwr |-> wake_o) else $error("no wake");
   reset_quiet_a:
   assert property ($rose(resetn_i) |-> !irq_o && !wake_o && prdata_o == 32'h0)
      else $error("reset values");
   irq_cause_a:
   assert property ($rose(irq_o) |-> pin_act || $past(wr) || $past(wr, 2))
      else $error("irq without cause");
endmodule : icc_capture_chk

bind icc_capture icc_capture_chk u_chk (.clk_sys_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .prdata_o, .pready_o, .pslverr_o, .capture_pin_i, .cpu_idle_i, .cpu_sleep_i,
   .irq_o, .wake_o);

// ===== verification/icc_src_model.sv
// Capture pin and timer source model
`timescale 1ns/1ps
module icc_src_model (
   input wire logic clk_sys_i,
   output logic pin_o,
   output icc_pkg::icc_timers_type timers_o
);
   import icc_pkg::*;
   logic hold = 1'b0;
   initial begin
      pin_o = 1'b0;
      timers_o = '0;
   end
   // Timers run free, frozen only while a pulse is in flight
   always @(posedge clk_sys_i) begin
      if (!hold) begin
         timers_o <= timers_o + 32'h0001_0003;
      end
   end
   task automatic pulse(input logic [15:0] v);
      @(posedge clk_sys_i);
      hold <= 1'b1;
      @(posedge clk_sys_i);
      timers_o <= {v, ~v};
      @(posedge clk_sys_i);
      pin_o <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      pin_o <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      hold <= 1'b0;
   endtask : pulse
endmodule : icc_src_model

// ===== verification/tb_top.sv
// Directed bench for the input capture channel
`timescale 1ns/1ps
module tb_top;
   import icc_pkg::*;
   logic clk_sys_i, resetn, psel, pen, pwr, pslverr, pready, irq, wake, pin, idle, sleep, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   icc_timers_type tmr;
   int fails = 0;
   int num_checks = 0;
   // Mode table: mode, count field, pulses, captures, interrupt
   logic [2:0] md [0:9] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
   logic [1:0] cpi [0:9] = '{2'h0, 2'h1, 2'h3, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
   int np [0:9] = '{2, 2, 1, 2, 3, 3, 4, 16, 2, 2};
   int nc [0:9] = '{0, 4, 2, 2, 3, 3, 1, 1, 0, 0};
   logic ni [0:9] = '{0, 1, 1, 1, 1, 0, 1, 1, 0, 0};
   icc_capture DUT (.clk_sys_i, .resetn_i(resetn), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .capture_pin_i(pin), .timers_i(tmr),
      .cpu_idle_i(idle), .cpu_sleep_i(sleep), .irq_o(irq), .wake_o(wake));
   icc_src_model src (.clk_sys_i, .pin_o(pin), .timers_o(tmr));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      num_checks++;
      if (got !== want) begin
         fails++;
         $display("ERROR %0t got %h want %h", $time, got, want);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      pen <= 1'b1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic t_reset();
      apb(1'b0, ICC_CTRL_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, ICC_PMD_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, ICC_IRQ_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      $display("test reset done");
   endtask : t_reset
   task automatic t_modes();
      int e;
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, ICC_CTRL_OFS, 32'h0);
         apb(1'b1, ICC_CTRL_OFS, {25'h0, cpi[i], 2'b00, md[i]});
         apb(1'b1, ICC_IRQ_OFS, 32'h40);
         for (int k = 0; k < np[i]; k++) src.pulse(16'h1000 + 16'(k));
         chk({31'h0, irq}, {31'h0, ni[i]});
         apb(1'b0, ICC_CTRL_OFS, 32'h0);
         chk({31'h0, rd[ICC_BNE_BIT]}, 32'(nc[i] > 0));
         for (int k = 0; k < nc[i]; k++) begin
            e = (nc[i] == np[i]) ? k : ((nc[i] > np[i]) ? k / 2 : np[i] - 1);
            apb(1'b0, ICC_BUF_OFS, 32'h0);
            chk({16'h0, rd[15:0]}, {16'h0, ~(16'h1000 + 16'(e))});
         end
         apb(1'b0, ICC_CTRL_OFS, 32'h0);
         chk({31'h0, rd[ICC_BNE_BIT]}, 32'h0);
      end
      $display("test modes done");
   endtask : t_modes
   task automatic t_wake();
      sleep <= 1'b1;
      src.pulse(16'h2222);
      chk({30'h0, irq, wake}, 32'h3);
      sleep <= 1'b0;
      @(posedge clk_sys_i);
      chk({31'h0, wake}, 32'h0);
      apb(1'b1, ICC_IRQ_OFS, 32'h40);
      @(posedge clk_sys_i);
      chk({31'h0, irq}, 32'h0);
      $display("test wake done");
   endtask : t_wake
   task automatic t_idle();
      idle <= 1'b1;
      apb(1'b1, ICC_CTRL_OFS, 32'h2003);
      src.pulse(16'h3333);
      apb(1'b0, ICC_CTRL_OFS, 32'h0);
      chk(rd, 32'h2003);
      apb(1'b1, ICC_CTRL_OFS, 32'h0083);
      src.pulse(16'h4444);
      apb(1'b0, ICC_BUF_OFS, 32'h0);
      chk({16'h0, rd[15:0]}, 32'h4444);
      idle <= 1'b0;
      $display("test idle done");
   endtask : t_idle
   task automatic t_ovf();
      apb(1'b1, ICC_CTRL_OFS, 32'h0);
      apb(1'b1, ICC_CTRL_OFS, 32'h001b);
      apb(1'b0, ICC_CTRL_OFS, 32'h0);
      chk(rd, 32'h0003);
      for (int k = 0; k < 5; k++) src.pulse(16'h5000 + 16'(k));
      apb(1'b0, ICC_CTRL_OFS, 32'h0);
      chk(rd, 32'h001b);
      for (int k = 0; k < 4; k++) begin
         apb(1'b0, ICC_BUF_OFS, 32'h0);
         chk({16'h0, rd[15:0]}, {16'h0, ~(16'h5000 + 16'(k))});
      end
      apb(1'b0, ICC_CTRL_OFS, 32'h0);
      chk(rd, 32'h0003);
      $display("test overflow done");
   endtask : t_ovf
   task automatic t_pmd();
      apb(1'b1, ICC_CTRL_OFS, 32'h2065);
      apb(1'b1, ICC_PMD_OFS, 32'h1);
      apb(1'b1, ICC_CTRL_OFS, 32'h0);
      apb(1'b0, ICC_CTRL_OFS, 32'h0);
      chk(rd, ICC_INVALID_RD);
      apb(1'b0, ICC_PMD_OFS, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, ICC_PMD_OFS, 32'h0);
      apb(1'b0, ICC_CTRL_OFS, 32'h0);
      chk(rd, 32'h2065);
      $display("test disable done");
   endtask : t_pmd
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (30000) @(posedge clk_sys_i);
      fails++;
      give_verdict();
   end
   initial begin
      {resetn, psel, pen, pwr, idle, sleep} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (8) @(posedge clk_sys_i);
      resetn <= 1'b1;
      t_reset();
      t_modes();
      t_wake();
      t_idle();
      t_ovf();
      t_pmd();
      give_verdict();
   end
endmodule : tb_top
